// ==== common/pcif_pkg.sv ====
// Package for the pulse command input front end: register map and types.
package pcif_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_FLT = 8'h04;
  localparam logic [7:0] ADDR_MUL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_POS = 8'h10;
  localparam logic [7:0] ADDR_RATE = 8'h14;
  localparam logic [7:0] ADDR_INT = 8'h18;
  // Reset values and limits.
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [3:0] FSEL_RST = 4'h0;
  localparam logic [12:0] CUST_RST = 13'h0190;
  localparam logic [12:0] CUST_MAX = 13'h1388;
  localparam logic [6:0] MULF_RST = 7'h01;
  localparam logic [6:0] MULF_MAX = 7'h64;
  localparam logic [1:0] MMODE_RST = 2'h0;
  localparam logic [3:0] FSEL_CUSTOM = 4'h8;
  // Source codes.
  localparam logic [1:0] SRC_HS = 2'h0;
  localparam logic [1:0] SRC_LS = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h3;
  // Multiplier modes.
  localparam logic [1:0] MM_OFF = 2'h0;
  localparam logic [1:0] MM_ON = 2'h1;
  localparam logic [1:0] MM_PIN = 2'h2;
  // Timing: custom step 12.5 ns = 25/2 ns; clock period 20 ns.
  localparam int CLK_PS = 20000;
  localparam int STEP_PS = 12500;
  localparam int RATE_WIN_NS = 1000000;
  localparam int RATE_WIN_CYC = RATE_WIN_NS * 1000 / CLK_PS;
  // Preset filter widths in ns, codes 0..7.
  localparam int PRESET_NS [8] = '{40, 80, 150, 300, 600, 1000, 2000, 5000};
  // Configuration carried together.
  typedef struct packed {
    logic [1:0] src;
    logic [3:0] fsel;
    logic [12:0] cust;
    logic [6:0] mulf;
    logic [1:0] mmode;
  } pcif_cfg_t;
endpackage

// ==== logic/pcif_top.sv ====
// Pulse command front end: source select, glitch filter, multiplier, AHB.
// Functional notes
// - Position is the accumulated pulse count; speed is the pulse rate.
// - Source select: high-speed, low-speed, reserved, internal; default 0.
// - Filter codes 0 to 7 pick presets; code 8 uses custom time.
// - Custom filter time 0 to 5000 steps of 12.5 ns; default 400.
// - Pulses narrower than the active filter width are dropped uncounted.
// - With 150 ns filter, segments below 150 ns merge neighbour pulses.
// - Active multiplier scales each counted pulse by factor 1 to 100.
// - Status output shows whether the multiplier is switched in.
// - Mode 0 disables, 1 forces, 2 follows the switch input level.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module pcif_top (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Pulse and switch pins
  input wire logic I_PULSE_HS,
  input wire logic I_PULSE_LS,
  input wire logic I_MUL_SWITCH,
  // Internal command pulse from the drive's own generator
  input wire logic I_INT_PULSE,
  // Outputs
  output logic O_MULTIPLIER_ACTIVE_OUT,
  output logic O_CMD_PULSE,
  output logic [31:0] O_POSITION
);

  function automatic logic [15:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + pcif_pkg::CLK_PS - 1) / pcif_pkg::CLK_PS;
    if (c < 1) c = 1;
    return 16'(c);
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Two-flop synchronisers for the pins.
  logic [2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {I_MUL_SWITCH, I_PULSE_LS, I_PULSE_HS};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Registers.
  pcif_pkg::pcif_cfg_t cfg_q, cfg_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic clr_pos;
  logic addr_ok;
  logic [7:0] a;
  assign a = I_HADDR[7:0];
  assign addr_ok = (I_HADDR[31:8] == 24'h000000);

  // Filter state and counting.
  logic flt_lvl_q, flt_lvl_d;
  logic [15:0] flt_cnt_q, flt_cnt_d;
  logic [15:0] flt_cyc;
  logic raw_in;
  logic pulse_q, pulse_d;
  logic [31:0] pos_q, pos_d;
  logic [31:0] rate_acc_q, rate_acc_d, rate_q, rate_d;
  logic [15:0] win_q, win_d;
  logic mul_act_q, mul_act_d;

  always_comb begin
    cfg_d = cfg_q;
    hrdata_d = hrdata_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    clr_pos = 1'b0;
    if (wr_pend_q) begin
      case (wr_addr_q)
        pcif_pkg::ADDR_CFG: begin
          cfg_d.src = I_HWDATA[1:0];
          cfg_d.mmode = I_HWDATA[5:4];
        end
        pcif_pkg::ADDR_FLT: begin
          if (I_HWDATA[3:0] <= pcif_pkg::FSEL_CUSTOM)
            cfg_d.fsel = I_HWDATA[3:0];
          if (I_HWDATA[28:16] <= pcif_pkg::CUST_MAX)
            cfg_d.cust = I_HWDATA[28:16];
        end
        pcif_pkg::ADDR_MUL: begin
          if (I_HWDATA[6:0] >= pcif_pkg::MULF_RST &&
              I_HWDATA[6:0] <= pcif_pkg::MULF_MAX)
            cfg_d.mulf = I_HWDATA[6:0];
        end
        pcif_pkg::ADDR_POS: clr_pos = 1'b1;
        default: ;
      endcase
    end
    if (I_HSEL && I_HREADY && I_HTRANS[1]) begin
      wr_pend_d = I_HWRITE && addr_ok;
      wr_addr_d = a;
      hrdata_d = 32'h00000000;
      if (!I_HWRITE && addr_ok) begin
        case (a)
          pcif_pkg::ADDR_CFG:
            hrdata_d = {26'h0, cfg_q.mmode, 2'h0, cfg_q.src};
          pcif_pkg::ADDR_FLT:
            hrdata_d = {3'h0, cfg_q.cust, 12'h000, cfg_q.fsel};
          pcif_pkg::ADDR_MUL: hrdata_d = {25'h0, cfg_q.mulf};
          pcif_pkg::ADDR_STAT:
            hrdata_d = {29'h0, flt_lvl_q, pin_s2_q[2], mul_act_q};
          pcif_pkg::ADDR_POS: hrdata_d = pos_q;
          pcif_pkg::ADDR_RATE: hrdata_d = rate_q;
          default: hrdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{pcif_pkg::SRC_RST, pcif_pkg::FSEL_RST, pcif_pkg::CUST_RST,
                 pcif_pkg::MULF_RST, pcif_pkg::MMODE_RST};
      hrdata_q <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      hrdata_q <= hrdata_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // Active filter width in clock cycles; custom steps round up.
  always_comb begin
    if (cfg_q.fsel == pcif_pkg::FSEL_CUSTOM) begin
      flt_cyc = 16'((32'(cfg_q.cust) * pcif_pkg::STEP_PS
                + pcif_pkg::CLK_PS - 1) / pcif_pkg::CLK_PS);
      if (flt_cyc == 16'h0000) flt_cyc = 16'h0001;
    end else begin
      flt_cyc = ns_to_cyc(pcif_pkg::PRESET_NS[cfg_q.fsel[2:0]]);
    end
  end

  // Source multiplexer; reserved code passes nothing.
  always_comb begin
    case (cfg_q.src)
      pcif_pkg::SRC_HS: raw_in = pin_s2_q[0];
      pcif_pkg::SRC_LS: raw_in = pin_s2_q[1];
      pcif_pkg::SRC_INT: raw_in = I_INT_PULSE;
      default: raw_in = 1'b0;
    endcase
  end

  // Short segments never reach the counter, so adjacent pulses merge.
  always_comb begin
    flt_lvl_d = flt_lvl_q;
    flt_cnt_d = 16'h0000;
    if (raw_in != flt_lvl_q) begin
      flt_cnt_d = flt_cnt_q + 16'h0001;
      if (flt_cnt_d >= flt_cyc) begin
        flt_lvl_d = raw_in;
        flt_cnt_d = 16'h0000;
      end
    end
  end

  // Multiplier gating applies to every source, internal one included.
  always_comb begin
    case (cfg_q.mmode)
      pcif_pkg::MM_OFF: mul_act_d = 1'b0;
      pcif_pkg::MM_ON: mul_act_d = 1'b1;
      pcif_pkg::MM_PIN: mul_act_d = pin_s2_q[2];
      default: mul_act_d = 1'b0;
    endcase
  end

  // Count on each accepted rising edge; rate over a 1 ms window.
  always_comb begin
    logic rise;
    rise = flt_lvl_d && !flt_lvl_q;
    pulse_d = rise;
    pos_d = clr_pos ? 32'h00000000 : pos_q;
    rate_acc_d = rate_acc_q;
    rate_d = rate_q;
    win_d = win_q + 16'h0001;
    if (rise) begin
      pos_d = pos_d + (mul_act_q ? 32'(cfg_q.mulf) : 32'h00000001);
      rate_acc_d = rate_acc_q + 32'h00000001;
    end
    if (win_q == 16'(pcif_pkg::RATE_WIN_CYC - 1)) begin
      rate_d = rate_acc_d;
      rate_acc_d = 32'h00000000;
      win_d = 16'h0000;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flt_lvl_q <= 1'b0;
      flt_cnt_q <= 16'h0000;
      pulse_q <= 1'b0;
      pos_q <= 32'h00000000;
      rate_acc_q <= 32'h00000000;
      rate_q <= 32'h00000000;
      win_q <= 16'h0000;
      mul_act_q <= 1'b0;
    end else begin
      flt_lvl_q <= flt_lvl_d;
      flt_cnt_q <= flt_cnt_d;
      pulse_q <= pulse_d;
      pos_q <= pos_d;
      rate_acc_q <= rate_acc_d;
      rate_q <= rate_d;
      win_q <= win_d;
      mul_act_q <= mul_act_d;
    end
  end

  assign O_HRDATA = hrdata_q;
  assign O_HREADYOUT = rst_sync_q[1];
  assign O_HRESP = 1'b0;
  assign O_MULTIPLIER_ACTIVE_OUT = mul_act_q;
  assign O_CMD_PULSE = pulse_q;
  assign O_POSITION = pos_q;

  chk_filter_hold: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    flt_lvl_q != $past(flt_lvl_q) |-> $past(flt_cnt_q) + 16'h0001
      >= $past(flt_cyc)) else $error("Level accepted early.");
  chk_short_drop: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    (raw_in != flt_lvl_q && flt_cnt_q + 16'h0001 < flt_cyc) |=>
      flt_lvl_q == $past(flt_lvl_q)) else $error("Glitch passed.");
  // The 150 ns preset keeps segments of eight cycles (160 ns) or more.
  chk_merge_150: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    (cfg_q.fsel == 4'h2 && raw_in != flt_lvl_q) |->
      (flt_lvl_d != flt_lvl_q) == (flt_cnt_q >= 16'h0007))
    else $error("Segment around 150 ns misjudged.");
  chk_mul_count: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    (pulse_d && mul_act_q && !clr_pos) |=>
      pos_q == $past(pos_q) + 32'($past(cfg_q.mulf)))
    else $error("Scaled count wrong.");
  chk_unit_count: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    (pulse_d && !mul_act_q && !clr_pos) |=>
      pos_q == $past(pos_q) + 32'h00000001) else $error("Count.");
  chk_mode_off: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    cfg_q.mmode == pcif_pkg::MM_OFF ##1 cfg_q.mmode == pcif_pkg::MM_OFF
      |-> !O_MULTIPLIER_ACTIVE_OUT) else $error("Mode off.");
  chk_mode_pin: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    cfg_q.mmode == pcif_pkg::MM_PIN |=>
      O_MULTIPLIER_ACTIVE_OUT == $past(pin_s2_q[2]))
    else $error("Pin mode.");
  chk_factor_range: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    cfg_q.mulf >= 7'h01 && cfg_q.mulf <= 7'h64)
    else $error("Factor range.");
  chk_custom_range: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    cfg_q.cust <= 13'h1388 && cfg_q.fsel <= 4'h8)
    else $error("Filter config.");
  chk_reserved_src: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    cfg_q.src == 2'h2 |-> !raw_in) else $error("Reserved src.");
endmodule

// ==== verification/pcif_ctrl_model.sv ====
// Upper controller model: emits bursts of command pulses on request.
`timescale 1ns/1ps
module pcif_ctrl_model (
  // Clock
  input wire logic i_clk,
  // Burst request
  input wire logic i_go,
  input wire logic [7:0] i_num,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_lo,
  // Pulse line and activity
  output logic o_pulse,
  output logic o_busy
);
  int n;
  // The line rests low between bursts, as an idle pulse output would.
  initial begin
    o_pulse = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        for (n = 0; n < i_num; n++) begin
          o_pulse <= 1'b1;
          repeat (i_hi) @(posedge i_clk);
          o_pulse <= 1'b0;
          repeat (i_lo) @(posedge i_clk);
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the pulse command front end.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic I_CLK = 1'b0, I_ARST_N = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic go = 1'b0, sw = 1'b0, pulse, busy, hready, hresp, act, cmd;
  logic [31:0] haddr = '0, hwdata = '0, rdata, hrdata, pos;
  logic [1:0] htrans = 2'h0, route = 2'h0;
  logic [7:0] num = 8'h01, hi = 8'h01, lo = 8'h01;
  int miscompares = 0, cmp_count = 0;
  int ncmd = 0, ncmd0 = 0;
  always #10 I_CLK = ~I_CLK;
  // Counts the one-cycle command pulses, one per accepted rising edge.
  always @(posedge I_CLK) if (cmd === 1'b1) ncmd <= ncmd + 1;
  pcif_ctrl_model pcif_ctrl_model_inst (.i_clk(I_CLK), .i_go(go),
    .i_num(num), .i_hi(hi), .i_lo(lo), .o_pulse(pulse), .o_busy(busy));
  pcif_top pcif_top_inst (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_PULSE_HS(pulse & (route == 2'h0)), .I_PULSE_LS(pulse & (route == 2'h1)),
    .I_MUL_SWITCH(sw), .I_INT_PULSE(pulse & (route == 2'h3)),
    .O_MULTIPLIER_ACTIVE_OUT(act), .O_CMD_PULSE(cmd), .O_POSITION(pos));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge I_CLK); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge I_CLK); while (hready !== 1'b1);
    rdata = hrdata;
  endtask
  // Clears the count, sends a burst, lets the filter settle, reads back.
  task automatic run(input logic [7:0] n, h, l, input int w);
    ncmd0 = ncmd;
    bus(1'b1, pcif_pkg::ADDR_POS, 32'h0);
    @(posedge I_CLK);
    num <= n;
    hi <= h;
    lo <= l;
    go <= 1'b1;
    do @(posedge I_CLK); while (busy !== 1'b1);
    go <= 1'b0;
    do @(posedge I_CLK); while (busy !== 1'b0);
    repeat (w) @(posedge I_CLK);
    bus(1'b0, pcif_pkg::ADDR_POS, 32'h0);
  endtask
  task automatic t_reset();
    bus(1'b0, pcif_pkg::ADDR_CFG, 32'h0);
    `CHK(rdata, 32'h00000000)
    bus(1'b0, pcif_pkg::ADDR_FLT, 32'h0);
    `CHK(rdata, 32'h01900000)
    bus(1'b0, pcif_pkg::ADDR_MUL, 32'h0);
    `CHK(rdata, 32'h00000001)
    bus(1'b0, 8'h1C, 32'h0);
    `CHK(rdata, 32'h00000000)
    `CHK(hresp, 1'b0)
  endtask
  task automatic t_filter();
    run(8'h05, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000005)
    `CHK(pos, 32'h00000005)
    `CHK(ncmd - ncmd0, 5)
    bus(1'b1, pcif_pkg::ADDR_FLT, 32'h01900002);
    run(8'h03, 8'h04, 8'h04, 14);
    `CHK(rdata, 32'h00000000)
    run(8'h03, 8'h0C, 8'h04, 14);
    `CHK(rdata, 32'h00000001)
    `CHK(ncmd - ncmd0, 1)
    run(8'h03, 8'h0C, 8'h0C, 14);
    `CHK(rdata, 32'h00000003)
    bus(1'b1, pcif_pkg::ADDR_FLT, 32'h00280008);
    run(8'h02, 8'h14, 8'h1E, 31);
    `CHK(rdata, 32'h00000000)
    run(8'h02, 8'h1E, 8'h1E, 31);
    `CHK(rdata, 32'h00000002)
    bus(1'b1, pcif_pkg::ADDR_FLT, 32'h13890008);
    bus(1'b0, pcif_pkg::ADDR_FLT, 32'h0);
    `CHK(rdata, 32'h00280008)
    bus(1'b1, pcif_pkg::ADDR_FLT, 32'h13880008);
    bus(1'b0, pcif_pkg::ADDR_FLT, 32'h0);
    `CHK(rdata, 32'h13880008)
    bus(1'b1, pcif_pkg::ADDR_FLT, 32'h01900000);
  endtask
  task automatic t_mult();
    bus(1'b1, pcif_pkg::ADDR_MUL, 32'h3);
    run(8'h02, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000002)
    bus(1'b1, pcif_pkg::ADDR_CFG, 32'h10);
    run(8'h02, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000006)
    `CHK(ncmd - ncmd0, 2)
    `CHK(pos, 32'h00000006)
    `CHK(act, 1'b1)
    bus(1'b1, pcif_pkg::ADDR_CFG, 32'h20);
    run(8'h02, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000002)
    `CHK(act, 1'b0)
    sw <= 1'b1;
    run(8'h02, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000006)
    bus(1'b0, pcif_pkg::ADDR_STAT, 32'h0);
    `CHK(rdata, 32'h00000003)
    bus(1'b1, pcif_pkg::ADDR_MUL, 32'h65);
    bus(1'b0, pcif_pkg::ADDR_MUL, 32'h0);
    `CHK(rdata, 32'h00000003)
    bus(1'b1, pcif_pkg::ADDR_MUL, 32'h64);
    run(8'h01, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000064)
    bus(1'b1, pcif_pkg::ADDR_CFG, 32'h0);
    sw <= 1'b0;
  endtask
  task automatic t_source();
    bus(1'b1, pcif_pkg::ADDR_CFG, 32'h1);
    run(8'h03, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000000)
    route <= 2'h1;
    run(8'h03, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000003)
    bus(1'b1, pcif_pkg::ADDR_CFG, 32'h2);
    run(8'h03, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000000)
    bus(1'b1, pcif_pkg::ADDR_CFG, 32'h3);
    route <= 2'h3;
    run(8'h03, 8'h04, 8'h04, 8);
    `CHK(rdata, 32'h00000003)
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge I_CLK);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    repeat (3) @(posedge I_CLK);
    t_reset();
    t_filter();
    t_mult();
    t_source();
    final_report();
  end
endmodule
